// ===== design/ipf_pkg.sv
// ipf_pkg: constants for the interrupt priority field bank.
// assumes a 32-bit apb slave, word-aligned registers in 12-bit space.
package ipf_pkg;

  // ==========================================================
  // sizes
  localparam int NSRC = 24;
  localparam int NREG = 9;
  localparam int PW = 3;
  localparam int IDW = 5;

  typedef logic [PW-1:0] ipf_prio_t;

  // ==========================================================
  // field values
  localparam ipf_prio_t PRIO_RST = 3'h4;
  localparam ipf_prio_t PRIO_OFF = 3'h0;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [11:0] REG_OFF [NREG] = '{
    12'h000, 12'h004, 12'h008, 12'h00c, 12'h010,
    12'h014, 12'h018, 12'h01c, 12'h028};
  localparam logic [11:0] EN_OFF = 12'h040;
  localparam logic [11:0] FLAG_OFF = 12'h044;
  localparam logic [11:0] STAT_OFF = 12'h048;

  // ==========================================================
  // status register layout
  localparam int STAT_UNACK_BIT = 15;
  localparam int STAT_PRIO_LSB = 8;
  localparam int STAT_ID_LSB = 0;

  // ==========================================================
  // source indices, also their fixed tie-break order
  localparam int TIMER_ONE_PRIO = 0;
  localparam int CAPCOMP2_EVENT_PRIO = 1;
  localparam int EXT_IRQ0_PRIO = 3;
  localparam int CAPCOMP4_EVENT_PRIO = 5;
  localparam int NONVOLATILE_PRIO = 9;
  localparam int CAPCOMP3_TIMER_PRIO = 18;
  localparam int CAPCOMP5_TIMER_PRIO = 23;

  // register slot holding each source's field
  localparam logic [3:0] SRC_REG [NSRC] = '{
    4'h0, 4'h0, 4'h0, 4'h0,
    4'h1, 4'h1, 4'h1,
    4'h2, 4'h2,
    4'h3, 4'h3, 4'h3,
    4'h4, 4'h4, 4'h4, 4'h4,
    4'h5, 4'h5,
    4'h6,
    4'h7, 4'h7, 4'h7, 4'h7,
    4'h8};
  // low bit of each source's field
  localparam logic [3:0] SRC_LSB [NSRC] = '{
    4'hc, 4'h8, 4'h4, 4'h0,
    4'hc, 4'h8, 4'h4,
    4'hc, 4'h0,
    4'hc, 4'h4, 4'h0,
    4'hc, 4'h8, 4'h4, 4'h0,
    4'h8, 4'h0,
    4'hc,
    4'hc, 4'h8, 4'h4, 4'h0,
    4'h4};

endpackage : ipf_pkg

// ===== design/ipf_bank.sv
// ipf_bank: per-source priority fields, enables, pending flags and
// the arbiter that offers the strongest pending source to the cpu.
// assumes apb master on CLK_IN; source requests are same-clock logic.
//
// Contract
// - 3-bit field, 111 is level 7
// - codes map linearly, 001 lowest live
// - field 000 disables the source
// - unused bits read zero, writes ignored
// - every field resets to 100
// - register 0 field layout
// - register 1 field layout
// - register 2 field layout
// - register 3 field layout
// - register 4 field layout
// - register 5 field layout
// - register 6 field layout
// - register 7 field layout
// - register 10 field layout
// - per-source enable bit gates requests
// - pending waits, flagged, until above cpu
`timescale 1ns/1ps
`default_nettype none

module ipf_bank
  import ipf_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [NSRC-1:0] SRC_REQ_IN,
  input wire logic [3:0] CPU_LEVEL_IN,
  input wire logic CPU_ACK_IN,
  output logic IRQ_REQ_OUT,
  output logic [IDW-1:0] IRQ_ID_OUT,
  output logic [PW-1:0] IRQ_PRIO_OUT,
  output logic UNACKED_OUT
);

  // ==========================================================
  // state
  typedef struct packed {
    ipf_prio_t [NSRC-1:0] prio;
    logic [NSRC-1:0] en;
    logic [NSRC-1:0] flag;
    logic [31:0] rdata;
    logic slverr;
    logic irq;
    logic unacked;
    logic [IDW-1:0] id;
    ipf_prio_t wprio;
  } ipf_state_t;

  localparam ipf_state_t ST_RST = '{
    prio: {NSRC{PRIO_RST}},
    en: '0,
    flag: '0,
    rdata: '0,
    slverr: 1'b0,
    irq: 1'b0,
    unacked: 1'b0,
    id: '0,
    wprio: PRIO_OFF};

  ipf_state_t s_q;
  ipf_state_t s_d;

  // ==========================================================
  // next state
  always_comb begin
    logic setup;
    logic wr;
    logic hit;
    logic err;
    logic [3:0] slot;
    logic [31:0] rd;
    logic [NSRC-1:0] clr;
    ipf_prio_t best_p;
    logic [IDW-1:0] best_i;
    setup = 1'b0;
    wr = 1'b0;
    hit = 1'b0;
    err = 1'b0;
    slot = 4'h0;
    rd = 32'h0;
    clr = '0;
    best_p = PRIO_OFF;
    best_i = '0;
    s_d = s_q;
    setup = PSEL_IN && !PENABLE_IN;
    wr = PSEL_IN && PENABLE_IN && PWRITE_IN;

    for (int r = 0; r < NREG; r++) begin
      if (PADDR_IN == REG_OFF[r]) begin
        hit = 1'b1;
        slot = 4'(r);
      end
    end

    // read mux; bits with no field stay zero
    if (hit) begin
      for (int k = 0; k < NSRC; k++) begin
        if (SRC_REG[k] == slot) begin
          rd[SRC_LSB[k] +: PW] = s_q.prio[k];
        end
      end
    end else if (PADDR_IN == EN_OFF) begin
      rd[NSRC-1:0] = s_q.en;
    end else if (PADDR_IN == FLAG_OFF) begin
      rd[NSRC-1:0] = s_q.flag;
    end else if (PADDR_IN == STAT_OFF) begin
      rd[STAT_UNACK_BIT] = s_q.unacked;
      rd[STAT_PRIO_LSB +: PW] = s_q.wprio;
      rd[STAT_ID_LSB +: IDW] = s_q.id;
    end else begin
      err = 1'b1;
    end

    // answer is prepared in setup so read data leaves a flop
    if (setup) begin
      s_d.rdata = PWRITE_IN ? 32'h0 : rd;
      s_d.slverr = err;
    end

    // writes land in the access phase, per byte lane
    if (wr && hit) begin
      for (int k = 0; k < NSRC; k++) begin
        if (SRC_REG[k] == slot && PSTRB_IN[SRC_LSB[k] / 8]) begin
          s_d.prio[k] = PWDATA_IN[SRC_LSB[k] +: PW];
        end
      end
    end else if (wr && PADDR_IN == EN_OFF) begin
      for (int k = 0; k < NSRC; k++) begin
        if (PSTRB_IN[k / 8]) begin
          s_d.en[k] = PWDATA_IN[k];
        end
      end
    end else if (wr && PADDR_IN == FLAG_OFF) begin
      for (int k = 0; k < NSRC; k++) begin
        clr[k] = PWDATA_IN[k] && PSTRB_IN[k / 8];
      end
    end

    // cpu taking the offered source retires its flag
    if (CPU_ACK_IN && s_q.irq) begin
      clr[s_q.id] = 1'b1;
    end
    // a new request in the clearing cycle is kept
    s_d.flag = (s_q.flag & ~clr) | SRC_REQ_IN;

    // strict compare keeps the lower index on ties
    for (int k = 0; k < NSRC; k++) begin
      if (s_q.flag[k] && s_q.en[k] && s_q.prio[k] > best_p) begin
        best_p = s_q.prio[k];
        best_i = IDW'(k);
      end
    end
    s_d.wprio = best_p;
    s_d.id = best_i;
    // only a level above the cpu's is passed on
    s_d.irq = (best_p != PRIO_OFF) && ({1'b0, best_p} > CPU_LEVEL_IN);
    s_d.unacked = (best_p != PRIO_OFF) && !({1'b0, best_p} > CPU_LEVEL_IN);
  end

  // ==========================================================
  // registers
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  // zero-wait slave: every access phase completes at once
  assign PREADY_OUT = PSEL_IN && PENABLE_IN;
  assign PRDATA_OUT = s_q.rdata;
  assign PSLVERR_OUT = s_q.slverr && PSEL_IN && PENABLE_IN;
  assign IRQ_REQ_OUT = s_q.irq;
  assign IRQ_ID_OUT = s_q.id;
  assign IRQ_PRIO_OUT = s_q.wprio;
  assign UNACKED_OUT = s_q.unacked;

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  a_reset_fields: assert property (
    $rose(RST_B_IN) |-> s_q.prio == {NSRC{PRIO_RST}})
    else $error("priority fields not at reset value");

  a_reg0_write: assert property (
    PSEL_IN && PENABLE_IN && PWRITE_IN && PSTRB_IN[1]
    && PADDR_IN == REG_OFF[0]
    |=> s_q.prio[TIMER_ONE_PRIO] == $past(PWDATA_IN[14:12]))
    else $error("timer field write lost");

  a_unused_zero: assert property (
    PSEL_IN && !PENABLE_IN && !PWRITE_IN
    && PADDR_IN == REG_OFF[6]
    |=> PRDATA_OUT[11:0] == 12'h000 && PRDATA_OUT[31:15] == 17'h00000)
    else $error("unused bits read nonzero");

  a_zero_disables: assert property (
    s_q.prio[EXT_IRQ0_PRIO] == PRIO_OFF
    |=> !(IRQ_REQ_OUT && IRQ_ID_OUT == 5'h03))
    else $error("disabled source forwarded");

  a_enable_gates: assert property (
    !s_q.en[EXT_IRQ0_PRIO]
    |=> !(IRQ_REQ_OUT && IRQ_ID_OUT == 5'h03))
    else $error("masked source forwarded");

  a_above_cpu: assert property (
    IRQ_REQ_OUT |-> {1'b0, IRQ_PRIO_OUT} > $past(CPU_LEVEL_IN))
    else $error("request not above cpu level");

  a_unacked_hold: assert property (
    UNACKED_OUT |-> !IRQ_REQ_OUT && IRQ_PRIO_OUT != PRIO_OFF)
    else $error("unacked flag inconsistent");

  a_flag_sticky: assert property (
    SRC_REQ_IN[CAPCOMP4_EVENT_PRIO] |=> s_q.flag[CAPCOMP4_EVENT_PRIO])
    else $error("pending flag not set");

  a_top_wins: assert property (
    s_q.flag[TIMER_ONE_PRIO] && s_q.en[TIMER_ONE_PRIO]
    && s_q.prio[TIMER_ONE_PRIO] == 3'h7
    |=> IRQ_ID_OUT == 5'h00 && IRQ_PRIO_OUT == 3'h7)
    else $error("highest source not chosen");

  a_reset_state: assert property (
    $rose(RST_B_IN)
    |-> s_q.en == '0 && s_q.flag == '0)
    else $error("enables or flags not clear after reset");

  a_reset_quiet: assert property (
    $rose(RST_B_IN)
    |-> !IRQ_REQ_OUT && !UNACKED_OUT && IRQ_PRIO_OUT == PRIO_OFF)
    else $error("offer present right after reset");

  a_reg0_gaps: assert property (
    PSEL_IN && !PENABLE_IN && !PWRITE_IN
    && PADDR_IN == REG_OFF[0]
    |=> !PRDATA_OUT[15] && !PRDATA_OUT[11] && !PRDATA_OUT[7]
    && !PRDATA_OUT[3] && PRDATA_OUT[31:16] == 16'h0000)
    else $error("register 0 gap bits nonzero");

  a_reg1_gaps: assert property (
    PSEL_IN && !PENABLE_IN && !PWRITE_IN
    && PADDR_IN == REG_OFF[1]
    |=> !PRDATA_OUT[15] && !PRDATA_OUT[11] && !PRDATA_OUT[7]
    && PRDATA_OUT[3:0] == 4'h0 && PRDATA_OUT[31:16] == 16'h0000)
    else $error("register 1 gap bits nonzero");

  a_reg2_gaps: assert property (
    PSEL_IN && !PENABLE_IN && !PWRITE_IN
    && PADDR_IN == REG_OFF[2]
    |=> !PRDATA_OUT[15] && PRDATA_OUT[11:3] == 9'h000
    && PRDATA_OUT[31:16] == 16'h0000)
    else $error("register 2 gap bits nonzero");

  a_reg3_gaps: assert property (
    PSEL_IN && !PENABLE_IN && !PWRITE_IN
    && PADDR_IN == REG_OFF[3]
    |=> !PRDATA_OUT[15] && PRDATA_OUT[11:7] == 5'h00
    && !PRDATA_OUT[3] && PRDATA_OUT[31:16] == 16'h0000)
    else $error("register 3 gap bits nonzero");

  a_reg4_gaps: assert property (
    PSEL_IN && !PENABLE_IN && !PWRITE_IN
    && PADDR_IN == REG_OFF[4]
    |=> !PRDATA_OUT[15] && !PRDATA_OUT[11] && !PRDATA_OUT[7]
    && !PRDATA_OUT[3] && PRDATA_OUT[31:16] == 16'h0000)
    else $error("register 4 gap bits nonzero");

  a_reg5_gaps: assert property (
    PSEL_IN && !PENABLE_IN && !PWRITE_IN
    && PADDR_IN == REG_OFF[5]
    |=> PRDATA_OUT[15:11] == 5'h00 && PRDATA_OUT[7:3] == 5'h00
    && PRDATA_OUT[31:16] == 16'h0000)
    else $error("register 5 gap bits nonzero");

  a_reg7_gaps: assert property (
    PSEL_IN && !PENABLE_IN && !PWRITE_IN
    && PADDR_IN == REG_OFF[7]
    |=> !PRDATA_OUT[15] && !PRDATA_OUT[11] && !PRDATA_OUT[7]
    && !PRDATA_OUT[3] && PRDATA_OUT[31:16] == 16'h0000)
    else $error("register 7 gap bits nonzero");

  a_reg10_gaps: assert property (
    PSEL_IN && !PENABLE_IN && !PWRITE_IN
    && PADDR_IN == REG_OFF[8]
    |=> PRDATA_OUT[15:7] == 9'h000 && PRDATA_OUT[3:0] == 4'h0
    && PRDATA_OUT[31:16] == 16'h0000)
    else $error("register 10 gap bits nonzero");

  a_reg6_write: assert property (
    PSEL_IN && PENABLE_IN && PWRITE_IN && PSTRB_IN[1]
    && PADDR_IN == REG_OFF[6]
    |=> s_q.prio[CAPCOMP3_TIMER_PRIO] == $past(PWDATA_IN[14:12]))
    else $error("capture 3 timer field write lost");

  a_reg10_write: assert property (
    PSEL_IN && PENABLE_IN && PWRITE_IN && PSTRB_IN[0]
    && PADDR_IN == REG_OFF[8]
    |=> s_q.prio[CAPCOMP5_TIMER_PRIO] == $past(PWDATA_IN[6:4]))
    else $error("capture 5 timer field write lost");

  a_lane_kept: assert property (
    PSEL_IN && PENABLE_IN && PWRITE_IN && !PSTRB_IN[1]
    && PADDR_IN == REG_OFF[1]
    |=> s_q.prio[CAPCOMP4_EVENT_PRIO]
    == $past(s_q.prio[CAPCOMP4_EVENT_PRIO]))
    else $error("field written with its lane off");

  a_error_zero: assert property (
    PSLVERR_OUT |-> PRDATA_OUT == 32'h0)
    else $error("refused access returned data");

  a_level_live: assert property (
    IRQ_REQ_OUT || UNACKED_OUT |-> IRQ_PRIO_OUT != PRIO_OFF)
    else $error("disabled level offered");

  a_unacked_level: assert property (
    UNACKED_OUT |-> {1'b0, IRQ_PRIO_OUT} <= $past(CPU_LEVEL_IN))
    else $error("unacked while above cpu level");

  a_ack_retires: assert property (
    CPU_ACK_IN && IRQ_REQ_OUT && IRQ_ID_OUT == 5'h00
    && !SRC_REQ_IN[TIMER_ONE_PRIO]
    |=> !s_q.flag[TIMER_ONE_PRIO])
    else $error("taken source still pending");

  a_flag_holds: assert property (
    s_q.flag[CAPCOMP4_EVENT_PRIO] && !CPU_ACK_IN
    && !(PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == FLAG_OFF)
    |=> s_q.flag[CAPCOMP4_EVENT_PRIO])
    else $error("pending flag dropped unasked");

  a_flag_clear: assert property (
    PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == FLAG_OFF
    && PWDATA_IN[CAPCOMP4_EVENT_PRIO] && PSTRB_IN[0]
    && !SRC_REQ_IN[CAPCOMP4_EVENT_PRIO]
    |=> !s_q.flag[CAPCOMP4_EVENT_PRIO])
    else $error("write one did not clear flag");

  a_idle_quiet: assert property (
    s_q.flag == '0 |=> !IRQ_REQ_OUT && !UNACKED_OUT)
    else $error("offer with nothing pending");

  a_tie_lower: assert property (
    s_q.flag[TIMER_ONE_PRIO] && s_q.en[TIMER_ONE_PRIO]
    && s_q.flag[EXT_IRQ0_PRIO] && s_q.en[EXT_IRQ0_PRIO]
    && s_q.prio[TIMER_ONE_PRIO] == s_q.prio[EXT_IRQ0_PRIO]
    |=> IRQ_ID_OUT != 5'h03)
    else $error("tie not broken by order");

  a_level_one_live: assert property (
    s_q.flag[TIMER_ONE_PRIO] && s_q.en[TIMER_ONE_PRIO]
    && s_q.prio[TIMER_ONE_PRIO] == 3'h1
    |=> IRQ_PRIO_OUT != PRIO_OFF)
    else $error("level one source not offered");

  a_level_seven: assert property (
    PSEL_IN && PENABLE_IN && PWRITE_IN && PSTRB_IN[0]
    && PADDR_IN == REG_OFF[0] && PWDATA_IN[2:0] == 3'h7
    |=> s_q.prio[EXT_IRQ0_PRIO] == 3'h7)
    else $error("level seven not stored");

endmodule : ipf_bank

`default_nettype wire

// ===== bench/ipf_cpu_model.sv
// ipf_cpu_model: cpu core stand-in that takes offered requests.
// assumes ipf_bank offers on the same clock and samples ack at edges.
`timescale 1ns/1ps
`default_nettype none
module ipf_cpu_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic req_in,
  input wire logic take_in,
  output logic ack_out
);
  logic [1:0] gap_q;
  // ==========================================================
  // take
  // offer lingers after a take, so hold off to avoid a double ack
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_out <= 1'b0;
      gap_q <= 2'h0;
    end else if (gap_q != 2'h0) begin
      ack_out <= 1'b0;
      gap_q <= gap_q - 2'h1;
    end else begin
      ack_out <= req_in && take_in;
      gap_q <= {2{req_in && take_in}};
    end
  end
endmodule : ipf_cpu_model
`default_nettype wire

// ===== bench/ipf_bank_tb_top.sv
// ipf_bank_tb_top: register and arbitration checks of ipf_bank.
// assumes ipf_cpu_model as the cpu and zero-wait apb answers.
`timescale 1ns/1ps
`default_nettype none
module ipf_bank_tb_top
  import ipf_pkg::*;
;
  logic clk, rst_b, psel, penable, pwrite, take, err, ack;
  logic pready, pslverr, irq, unacked;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdata, prdata;
  logic [3:0] strb, lvl;
  logic [NSRC-1:0] src;
  logic [IDW-1:0] id;
  logic [PW-1:0] prio;
  logic [15:0] rv [NREG] = '{default: 16'h0};
  logic [15:0] mk [NREG] = '{default: 16'h0};
  int num_errors = 0;
  int checks_done = 0;

  ipf_bank ipf_bank_inst (.CLK_IN(clk), .RST_B_IN(rst_b),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(strb),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .SRC_REQ_IN(src), .CPU_LEVEL_IN(lvl), .CPU_ACK_IN(ack),
    .IRQ_REQ_OUT(irq), .IRQ_ID_OUT(id), .IRQ_PRIO_OUT(prio),
    .UNACKED_OUT(unacked));
  ipf_cpu_model ipf_cpu_model_inst (.clk_in(clk), .rst_b_in(rst_b),
    .req_in(irq), .take_in(take), .ack_out(ack));

  // ==========================================================
  // tasks
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask : rd
  task automatic settle;
    repeat (3) @(posedge clk);
  endtask : settle
  // id only means something while a winner is shown
  task automatic st(input logic u, input logic q, input logic [2:0] p,
                    input logic [4:0] i);
    settle();
    chk({unacked, irq, prio, id & {IDW{irq | unacked}}}, {u, q, p, i});
  endtask : st
  task end_of_test;
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  // ==========================================================
  // clock, watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    end_of_test();
  end

  // ==========================================================
  // tests
  initial begin
    {rst_b, psel, penable, pwrite, take} = 5'h0;
    {paddr, pwdata, src, lvl} = '0;
    strb = 4'hf;
    for (int s = 0; s < NSRC; s++) begin
      rv[SRC_REG[s]] |= 16'(PRIO_RST) << SRC_LSB[s];
      mk[SRC_REG[s]] |= 16'h7 << SRC_LSB[s];
    end
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (int r = 0; r < NREG; r++) rd(REG_OFF[r], rv[r]);
    for (int r = 0; r < NREG; r++) begin
      apb(1'b1, REG_OFF[r], 32'hffffffff);
      rd(REG_OFF[r], mk[r]);
    end
    strb <= 4'h1;
    apb(1'b1, REG_OFF[1], 32'h0);
    strb <= 4'hf;
    rd(REG_OFF[1], 32'h7700);
    rd(12'h030, 32'h0);
    chk(err, 32'h1);
    for (int r = 0; r < NREG; r++) apb(1'b1, REG_OFF[r], 32'h0);
    apb(1'b1, EN_OFF, 32'h00ffffff);
    @(posedge clk);
    src <= 24'h29;
    @(posedge clk);
    src <= '0;
    st(0, 0, 0, 0);
    apb(1'b1, REG_OFF[0], 32'h1001);
    st(0, 1, 1, 0);
    apb(1'b1, REG_OFF[0], 32'h1007);
    st(0, 1, 7, 3);
    lvl <= 4'h7;
    st(1, 0, 7, 3);
    rd(STAT_OFF, 32'h8703);
    lvl <= 4'h0;
    apb(1'b1, EN_OFF, 32'h00fffff7);
    st(0, 1, 1, 0);
    take <= 1'b1;
    while (irq !== 1'b0) @(posedge clk);
    st(0, 0, 0, 0);
    rd(FLAG_OFF, 32'h28);
    apb(1'b1, FLAG_OFF, 32'h00000028);
    rd(FLAG_OFF, 32'h0);
    end_of_test();
  end
endmodule : ipf_bank_tb_top
`default_nettype wire
